// *** bench/tb_ncme_core.sv ***
// Self-checking random bench for the nibble compare, rotate and move block
`timescale 1ns/1ps
module tb_ncme_core import ncme_pkg::*;;
    logic clock = 1'b0, resetn = 1'b0, instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] instr_word = 16'h0000;    // Offered instruction
    logic [3:0] reg_addr = 4'h0;           // Register index
    logic [7:0] reg_wdata = 8'h00;         // Register write data
    logic [7:0] reg_rdata;                 // Register read data
    logic instr_ready, exec_done, skip_taken;
    int bad_count = 0, total_checks = 0;
    logic [3:0] mm [256];                  // Bench copy of data memory
    logic cy, ptr, idx, cmp, bk, pend, es; // Bench copy of mode state
    logic [3:0] rp, gp;                    // Pointer rows
    logic [7:0] ix, da, ia, ga;            // Index and computed addresses
    logic [4:0] ops [11] = '{SKIP_IF_UNEQUAL_OP, SKIP_IF_AT_LEAST_OP, SKIP_IF_BELOW_OP,
        SKIP_IF_EQUAL_OP, ROTATE_RIGHT_CARRY_OP, READ_MEMORY_TO_REG_OP, WRITE_REG_TO_MEMORY_OP,
        MOVE_TO_INDIRECT_OP, MOVE_FROM_INDIRECT_OP, STORE_IMMEDIATE_OP, 5'h00};
    ncme_core u_ncme_core (.clock(clock), .resetn(resetn), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .exec_done(exec_done),
        .skip_taken(skip_taken), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // ************************************************
    // Clock and shared tasks
    // ************************************************
    initial forever #12.5 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes, changed just after the edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic poke(input logic [7:0] a, input logic [3:0] d);
        wr(REG_MEM_ADDR, a); wr(REG_MEM_DATA, {4'h0, d}); mm[a] = d;
    endtask
    // Peek strobe lands two cycles after the address write
    task automatic peek(input logic [7:0] a);
        wr(REG_MEM_ADDR, a); rd(REG_MEM_DATA, {4'h0, mm[a]});
    endtask
    task automatic setup(input logic [3:0] c, input logic b, input logic [3:0] r,
        input logic [3:0] g, input logic [7:0] x);
        {cy, cmp, idx, ptr} = c; bk = b; rp = r; gp = g; ix = x;
        wr(REG_CTRL, {4'h0, c}); wr(REG_BANK, {7'h0, b}); wr(REG_ROW_PTR, {4'h0, r});
        wr(REG_GR_PTR, {4'h0, g}); wr(REG_INDEX, x);
    endtask
    // Bench model of one instruction, then drive it and time the retire
    task automatic run(input logic [15:0] w);
        logic [3:0] m, t, n;
        int k;
        n = w[3:0];
        ga = {gp, n};
        da = {bk, w[10:4]} | (idx ? ix : 8'h00);
        ia = ptr ? {rp, mm[ga]} : {bk, w[10:8], mm[ga]};
        m = mm[da]; t = mm[ga]; es = 1'b0;
        if (!pend) begin
            case (w[15:11])
                SKIP_IF_UNEQUAL_OP: es = (m != n);
                SKIP_IF_AT_LEAST_OP: es = (m >= n);
                SKIP_IF_BELOW_OP: es = (m < n);
                SKIP_IF_EQUAL_OP: es = (m == n);
                ROTATE_RIGHT_CARRY_OP: begin
                    mm[ga] = {cy, t[3:1]}; cy = t[0];
                end
                READ_MEMORY_TO_REG_OP: mm[ga] = m;
                WRITE_REG_TO_MEMORY_OP: mm[da] = t;
                MOVE_TO_INDIRECT_OP: mm[ia] = m;
                MOVE_FROM_INDIRECT_OP: mm[da] = mm[ia];
                STORE_IMMEDIATE_OP: mm[da] = n;
                default: ;
            endcase
        end
        pend = es;
        @(posedge clock);
        instr_valid <= 1'b1; instr_word <= w;
        @(posedge clock);
        instr_valid <= 1'b0; k = 0;
        #1 chk(8'(instr_ready), 8'h00);
        do begin
            @(posedge clock); #1 k++;
        end while (exec_done !== 1'b1 && k < 20);
        // Done pulse is launched four edges after the accept edge
        chk(8'(k), 8'h04);
        chk(8'(instr_ready), 8'h01);
        chk(8'(skip_taken), 8'(es));
        peek(da); peek(ia); peek(ga);
        rd(REG_CTRL, {4'h0, cy, cmp, idx, ptr});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ************************************************
    // Main sequence and watchdog
    // ************************************************
    initial begin
        #1ms bad_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(31379));
        pend = 1'b0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        rd(REG_CTRL, 8'h00); rd(REG_STATUS, 8'h00);
        wr(4'h9, 8'hff); rd(4'h9, 8'h00);
        for (int i = 0; i < 256; i++) poke(8'(i), 4'($urandom));
        // Equal compare then a skipped store of the immediate
        setup(4'h0, 1'b0, 4'h0, 4'h0, 8'h00); poke(8'h24, 4'h0);
        run({SKIP_IF_EQUAL_OP, 3'h2, 4'h4, 4'h0});
        run({STORE_IMMEDIATE_OP, 3'h2, 4'h4, 4'hf});
        for (int i = 0; i < 240; i++) begin
            if (i % 8 == 0) setup(4'($urandom), 1'($urandom), 4'($urandom), 4'($urandom),
                8'($urandom));
            run({ops[$urandom % 11], 11'($urandom)});
        end
        for (int i = 0; i < 256; i++) peek(8'(i));
        wrap_up();
    end
endmodule

// *** include/ncme_pkg.sv ***
// Shared constants, opcodes, register map and state codes for the nibble execute block
package ncme_pkg;

    // ******************************************************
    // Instruction word layout
    // ******************************************************
    localparam int OPC_HI = 15;  // Opcode top bit
    localparam int OPC_LO = 11;  // Opcode bottom bit
    localparam int ROW_HI = 10;  // Memory row top bit
    localparam int ROW_LO = 8;   // Memory row bottom bit
    localparam int COL_HI = 7;   // Memory column top bit
    localparam int COL_LO = 4;   // Memory column bottom bit
    localparam int OPD_HI = 3;   // Register or immediate top bit
    localparam int OPD_LO = 0;   // Register or immediate bottom bit

    // ******************************************************
    // Opcodes
    // ******************************************************
    localparam logic [4:0] SKIP_IF_UNEQUAL_OP = 5'h0b;     // 01011
    localparam logic [4:0] SKIP_IF_AT_LEAST_OP = 5'h19;    // 11001
    localparam logic [4:0] SKIP_IF_BELOW_OP = 5'h1b;       // 11011
    localparam logic [4:0] SKIP_IF_EQUAL_OP = 5'h09;       // Equality compare
    localparam logic [4:0] ROTATE_RIGHT_CARRY_OP = 5'h13;  // Rotate through carry
    localparam logic [4:0] READ_MEMORY_TO_REG_OP = 5'h08;  // 01000
    localparam logic [4:0] WRITE_REG_TO_MEMORY_OP = 5'h18; // 11000
    localparam logic [4:0] MOVE_TO_INDIRECT_OP = 5'h0a;    // 01010
    localparam logic [4:0] MOVE_FROM_INDIRECT_OP = 5'h1a;  // 11010
    localparam logic [4:0] STORE_IMMEDIATE_OP = 5'h1d;     // 11101

    // ******************************************************
    // Software register map (word index on the plain port)
    // ******************************************************
    localparam logic [3:0] REG_CTRL = 4'h0;      // Mode flags and carry
    localparam logic [3:0] REG_BANK = 4'h1;      // Current data memory bank
    localparam logic [3:0] REG_ROW_PTR = 4'h2;   // Indirect row pointer
    localparam logic [3:0] REG_GR_PTR = 4'h3;    // General register row
    localparam logic [3:0] REG_INDEX = 4'h4;     // Index register
    localparam logic [3:0] REG_MEM_ADDR = 4'h5;  // Peek and poke address
    localparam logic [3:0] REG_MEM_DATA = 4'h6;  // Peek and poke data
    localparam logic [3:0] REG_STATUS = 4'h7;    // Block state

    // Control register bits
    localparam int CTRL_PTR_MODE = 0;   // pointer_mode_flag
    localparam int CTRL_IDX_MODE = 1;   // index_mode_flag
    localparam int CTRL_CMP_HOLD = 2;   // compare_hold_flag
    localparam int CTRL_CARRY = 3;      // carry_flag

    // Status register bits
    localparam int STAT_BUSY = 0;       // Instruction in flight
    localparam int STAT_SKIP_PEND = 1;  // Next instruction runs as no-op
    localparam int STAT_LAST_SKIP = 2;  // Last executed compare asked for a skip

    // Reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ******************************************************
    // Execute sequencer states, one-hot
    // ******************************************************
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_REG = 5'b00010,
        S_MEM = 5'b00100,
        S_IND = 5'b01000,
        S_EXEC = 5'b10000
    } ncme_state_t;

endpackage

// *** rtl/ncme_core.sv ***
// Execute logic for compare-skip, rotate and data memory transfer instructions
`timescale 1ns/1ps
module ncme_core import ncme_pkg::*; (
    input wire logic clock,             // Core clock, 40 MHz
    input wire logic resetn,            // Asynchronous reset, active low
    input wire logic instr_valid,       // Instruction word offered
    input wire logic [15:0] instr_word, // Instruction word
    output logic instr_ready,           // Idle, next word is taken
    output logic exec_done,             // Pulse when an instruction retires
    output logic skip_taken,            // Pulse: next instruction must be skipped
    input wire logic [3:0] reg_addr,    // Register index
    input wire logic [7:0] reg_wdata,   // Register write data
    input wire logic reg_wr,            // Register write strobe
    input wire logic reg_rd,            // Register read strobe
    output logic [7:0] reg_rdata        // Read data, cycle after the strobe
);

    // ******************************************************
    // State
    // ******************************************************
    ncme_state_t state, next_state;       // Sequencer
    logic [15:0] instr, next_instr;       // Word in flight
    logic nop_cur, next_nop_cur;          // Word in flight is being skipped
    logic skip_pend, next_skip_pend;      // Skip the next accepted word
    logic last_skip, next_last_skip;      // Last compare result
    logic [3:0] reg_val, next_reg_val;    // General register nibble
    logic [3:0] m_val, next_m_val;        // Direct operand nibble
    logic [3:0] ctrl, next_ctrl;          // Mode flags and carry
    logic bank, next_bank;                // Current bank
    logic [3:0] row_ptr, next_row_ptr;    // row_pointer: bank and row
    logic [3:0] gr_ptr, next_gr_ptr;      // General register bank and row
    logic [7:0] index_reg, next_index_reg; // Index register
    logic [7:0] peek_addr, next_peek_addr; // Software memory address
    logic [3:0] peek_data, next_peek_data; // Software peek result
    logic peek_pend, next_peek_pend;      // Peek read in flight
    logic next_ready, next_done, next_skip_taken; // Output flops
    logic [7:0] next_rdata;               // Read data flop

    // Memory port
    logic mem_we;          // Write enable
    logic [7:0] mem_addr;  // Address
    logic [3:0] mem_wdata; // Write data
    logic [3:0] mem_rdata; // Registered read data

    // ******************************************************
    // Decode
    // ******************************************************
    logic [4:0] opcode;           // Opcode field
    logic [2:0] row_field;        // bank_row_field
    logic [3:0] column_field;     // Column field
    logic [3:0] immediate_nibble; // Register select or immediate
    logic [7:0] gr_addr;          // General register nibble address
    logic [7:0] m_addr;           // Effective direct address
    logic [7:0] ind_addr;         // Indirect address
    logic [4:0] diff;             // Memory minus immediate, with borrow
    logic is_compare;             // Compare-and-skip opcode
    logic skip_cond;              // Compare says skip

    assign opcode = instr[OPC_HI:OPC_LO];
    assign row_field = instr[ROW_HI:ROW_LO];
    assign column_field = instr[COL_HI:COL_LO];
    assign immediate_nibble = instr[OPD_HI:OPD_LO];
    assign gr_addr = {gr_ptr, immediate_nibble};

    // Index OR on the direct operand
    assign m_addr = {bank, row_field, column_field} |
                    (ctrl[CTRL_IDX_MODE] ? index_reg : 8'h00);

    // Row from pointer or from the encoded operand
    assign ind_addr = ctrl[CTRL_PTR_MODE] ? {row_ptr, reg_val} :
                      {bank, row_field, reg_val};

    // Borrow is the top bit of the 5-bit difference
    assign diff = {1'b0, m_val} - {1'b0, immediate_nibble};
    assign is_compare = (opcode == SKIP_IF_UNEQUAL_OP) || (opcode == SKIP_IF_AT_LEAST_OP) ||
                        (opcode == SKIP_IF_BELOW_OP) || (opcode == SKIP_IF_EQUAL_OP);

    // Skip decision
    always_comb begin
        case (opcode)
            SKIP_IF_UNEQUAL_OP: skip_cond = (diff[3:0] != 4'h0);
            SKIP_IF_AT_LEAST_OP: skip_cond = !diff[4];
            SKIP_IF_BELOW_OP: skip_cond = diff[4];
            SKIP_IF_EQUAL_OP: skip_cond = (diff[3:0] == 4'h0);
            default: skip_cond = 1'b0;
        endcase
    end

    // ******************************************************
    // Data memory
    // ******************************************************
    ncme_dmem u_ncme_dmem (
        .clock(clock),
        .resetn(resetn),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ******************************************************
    // Next-state logic for sequencer, registers and memory port
    // ******************************************************
    always_comb begin
        next_state = state;
        next_instr = instr;
        next_nop_cur = nop_cur;
        next_skip_pend = skip_pend;
        next_last_skip = last_skip;
        next_reg_val = reg_val;
        next_m_val = m_val;
        next_ctrl = ctrl;
        next_bank = bank;
        next_row_ptr = row_ptr;
        next_gr_ptr = gr_ptr;
        next_index_reg = index_reg;
        next_peek_addr = peek_addr;
        next_peek_data = peek_data;
        next_peek_pend = 1'b0;
        next_done = 1'b0;
        next_skip_taken = 1'b0;
        next_rdata = 8'h00;
        mem_we = 1'b0;
        mem_addr = peek_addr;
        mem_wdata = reg_wdata[3:0];

        // Peek result lands one cycle after its read was issued
        if (peek_pend) begin
            next_peek_data = mem_rdata;
        end

        // Software writes; hardware carry update below overrides
        if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                next_ctrl = reg_wdata[3:0];
            end else if (reg_addr == REG_BANK) begin
                next_bank = reg_wdata[0];
            end else if (reg_addr == REG_ROW_PTR) begin
                next_row_ptr = reg_wdata[3:0];
            end else if (reg_addr == REG_GR_PTR) begin
                next_gr_ptr = reg_wdata[3:0];
            end else if (reg_addr == REG_INDEX) begin
                next_index_reg = reg_wdata;
            end else if (reg_addr == REG_MEM_ADDR) begin
                next_peek_addr = reg_wdata;
                // Memory port is free only while idle
                if (state == S_IDLE) begin
                    mem_addr = reg_wdata;
                    next_peek_pend = 1'b1;
                end
            end else if (reg_addr == REG_MEM_DATA) begin
                // Poke ignored while an instruction is in flight
                mem_we = (state == S_IDLE);
            end
        end

        // Software reads; unmapped indexes return zero
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                next_rdata = {4'h0, ctrl};
            end else if (reg_addr == REG_BANK) begin
                next_rdata = {7'h00, bank};
            end else if (reg_addr == REG_ROW_PTR) begin
                next_rdata = {4'h0, row_ptr};
            end else if (reg_addr == REG_GR_PTR) begin
                next_rdata = {4'h0, gr_ptr};
            end else if (reg_addr == REG_INDEX) begin
                next_rdata = index_reg;
            end else if (reg_addr == REG_MEM_ADDR) begin
                next_rdata = peek_addr;
            end else if (reg_addr == REG_MEM_DATA) begin
                next_rdata = {4'h0, peek_data};
            end else if (reg_addr == REG_STATUS) begin
                next_rdata = {5'h00, last_skip, skip_pend, state != S_IDLE};
            end
        end

        case (state)
            S_IDLE: begin
                // A pending skip turns the next word into a no-op
                if (instr_valid) begin
                    next_instr = instr_word;
                    next_nop_cur = skip_pend;
                    next_skip_pend = 1'b0;
                    next_state = S_REG;
                end
            end
            S_REG: begin
                mem_we = 1'b0;
                mem_addr = gr_addr;
                next_state = S_MEM;
            end
            S_MEM: begin
                mem_we = 1'b0;
                next_reg_val = mem_rdata;
                mem_addr = m_addr;
                next_state = S_IND;
            end
            S_IND: begin
                // Indirect column uses the register nibble latched last cycle
                mem_we = 1'b0;
                next_m_val = mem_rdata;
                mem_addr = ind_addr;
                next_state = S_EXEC;
            end
            S_EXEC: begin
                mem_we = 1'b0;
                mem_addr = m_addr;
                mem_wdata = 4'h0;
                next_done = 1'b1;
                next_state = S_IDLE;
                if (!nop_cur) begin
                    case (opcode)
                        SKIP_IF_UNEQUAL_OP, SKIP_IF_AT_LEAST_OP,
                        SKIP_IF_BELOW_OP, SKIP_IF_EQUAL_OP: begin
                            // Flag effect only, no write back
                            next_last_skip = skip_cond;
                            next_skip_pend = skip_cond;
                            next_skip_taken = skip_cond;
                        end
                        ROTATE_RIGHT_CARRY_OP: begin
                            // Old carry in at bit 3, bit 0 out
                            mem_we = 1'b1;
                            mem_addr = gr_addr;
                            mem_wdata = {ctrl[CTRL_CARRY], reg_val[3:1]};
                            next_ctrl[CTRL_CARRY] = reg_val[0];
                        end
                        READ_MEMORY_TO_REG_OP: begin
                            mem_we = 1'b1;
                            mem_addr = gr_addr;
                            mem_wdata = m_val;
                        end
                        WRITE_REG_TO_MEMORY_OP: begin
                            mem_we = 1'b1;
                            mem_wdata = reg_val;
                        end
                        MOVE_TO_INDIRECT_OP: begin
                            mem_we = 1'b1;
                            mem_addr = ind_addr;
                            mem_wdata = m_val;
                        end
                        MOVE_FROM_INDIRECT_OP: begin
                            mem_we = 1'b1;
                            mem_wdata = mem_rdata;
                        end
                        STORE_IMMEDIATE_OP: begin
                            mem_we = 1'b1;
                            mem_wdata = immediate_nibble;
                        end
                        default: begin
                            // Other opcodes belong to other units
                            mem_we = 1'b0;
                        end
                    endcase
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        next_ready = (next_state == S_IDLE);
    end

    // ******************************************************
    // Registers
    // ******************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            instr <= 16'h0000;
            nop_cur <= 1'b0;
            skip_pend <= 1'b0;
            last_skip <= 1'b0;
            reg_val <= 4'h0;
            m_val <= 4'h0;
            ctrl <= CTRL_RESET;
            bank <= 1'b0;
            row_ptr <= PTR_RESET[3:0];
            gr_ptr <= PTR_RESET[3:0];
            index_reg <= PTR_RESET;
            peek_addr <= PTR_RESET;
            peek_data <= 4'h0;
            peek_pend <= 1'b0;
            instr_ready <= 1'b1;
            exec_done <= 1'b0;
            skip_taken <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            state <= next_state;
            instr <= next_instr;
            nop_cur <= next_nop_cur;
            skip_pend <= next_skip_pend;
            last_skip <= next_last_skip;
            reg_val <= next_reg_val;
            m_val <= next_m_val;
            ctrl <= next_ctrl;
            bank <= next_bank;
            row_ptr <= next_row_ptr;
            gr_ptr <= next_gr_ptr;
            index_reg <= next_index_reg;
            peek_addr <= next_peek_addr;
            peek_data <= next_peek_data;
            peek_pend <= next_peek_pend;
            instr_ready <= next_ready;
            exec_done <= next_done;
            skip_taken <= next_skip_taken;
            reg_rdata <= next_rdata;
        end
    end

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    logic live_exec; // Executing a word that is not skipped
    assign live_exec = (state == S_EXEC) && !nop_cur;

    sequence walk_s;
        state == S_REG ##1 state == S_MEM ##1 state == S_IND ##1 state == S_EXEC;
    endsequence

    chk_walk_order: assert property (
        (state == S_IDLE && instr_valid) |=> walk_s ##1 exec_done)
        else $error("execute walk out of order");
    chk_skip_unequal: assert property (
        (live_exec && opcode == SKIP_IF_UNEQUAL_OP) |=>
        (skip_taken == ($past(m_val) != $past(immediate_nibble))))
        else $error("unequal skip wrong");
    chk_skip_at_least: assert property (
        (live_exec && opcode == SKIP_IF_AT_LEAST_OP) |=>
        (skip_taken == ($past(m_val) >= $past(immediate_nibble))))
        else $error("at-least skip wrong");
    chk_skip_below: assert property (
        (live_exec && opcode == SKIP_IF_BELOW_OP) |=>
        (skip_taken == ($past(m_val) < $past(immediate_nibble))))
        else $error("below skip wrong");
    chk_skip_equal: assert property (
        (live_exec && opcode == SKIP_IF_EQUAL_OP) |=>
        (skip_taken == ($past(m_val) == $past(immediate_nibble))))
        else $error("equal skip wrong");
    // Accept with a skip pending, however long after the compare it comes
    chk_skipped_nop: assert property (
        (state == S_IDLE && instr_valid && skip_pend) |=>
        ##3 (state == S_EXEC && nop_cur && !mem_we) ##1 (exec_done && !skip_taken))
        else $error("skipped word had an effect");
    chk_compare_no_write: assert property (
        (state == S_EXEC && is_compare) |-> !mem_we)
        else $error("compare wrote memory");
    chk_rotate_carry: assert property (
        (live_exec && opcode == ROTATE_RIGHT_CARRY_OP) |->
        (mem_wdata == {ctrl[CTRL_CARRY], reg_val[3:1]}) ##1 (ctrl[CTRL_CARRY] == $past(reg_val[0])))
        else $error("rotate through carry wrong");
    chk_load_target: assert property (
        (live_exec && opcode == READ_MEMORY_TO_REG_OP) |-> (mem_we && mem_addr == gr_addr && mem_wdata == m_val))
        else $error("load target wrong");
    chk_index_or: assert property (
        (state == S_MEM && ctrl[CTRL_IDX_MODE]) |-> (mem_addr == ({bank, row_field, column_field} | index_reg)))
        else $error("index address wrong");
    chk_indirect_row: assert property (
        (state == S_IND && !ctrl[CTRL_PTR_MODE]) |-> (mem_addr[6:4] == row_field && mem_addr[7] == bank))
        else $error("indirect row wrong");

endmodule

// *** rtl/ncme_dmem.sv ***
// Nibble-wide data memory with a registered read port
`timescale 1ns/1ps
module ncme_dmem (
    input wire logic clock,         // Core clock
    input wire logic resetn,        // Asynchronous reset, active low
    input wire logic we,            // Write enable
    input wire logic [7:0] addr,    // Nibble address
    input wire logic [3:0] wdata,   // Write data
    output logic [3:0] rdata        // Read data, one cycle after addr
);

    // Array itself has no reset; software must initialise it
    logic [3:0] cells [0:255];

    // ******************************************************
    // Write and registered read
    // ******************************************************
    always_ff @(posedge clock) begin
        if (we) begin
            cells[addr] <= wdata;
        end
    end

    // Read returns old contents on a same-address write
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= 4'h0;
        end else begin
            rdata <= cells[addr];
        end
    end

endmodule
